// file: hdl/tcl_pkg.sv
// Constants, pin bundles and level codes for the transceiver control block
package tcl_pkg;

  // Three-level static select encoding
  localparam logic [1:0] LVL_LOW = 2'h0;
  localparam logic [1:0] LVL_MID = 2'h1;
  localparam logic [1:0] LVL_HIGH = 2'h2;

  // PLL range codes
  localparam logic [1:0] RANGE_195_400 = 2'h0;
  localparam logic [1:0] RANGE_400_800 = 2'h1;
  localparam logic [1:0] RANGE_800_1500 = 2'h2;

  // Timing: reference period and settle count after reset (below 16)
  localparam int REF_PERIOD_NS = 50;
  localparam logic [3:0] SETTLE_CYCLES = 4'h8;
  localparam logic [2:0] TMS_RESET_EDGES = 3'h5;

  // Elasticity buffer geometry and watermarks
  localparam int EB_DEPTH = 8;
  localparam logic [2:0] EB_NOMINAL = 3'h4;
  localparam logic [3:0] EB_FULL = 4'h8;
  localparam logic [3:0] EB_LOW_MARK = 4'h2;
  localparam logic [3:0] EB_HIGH_MARK = 4'h6;
  localparam logic [8:0] K28_5 = 9'h1BC;

  // Register offsets and reset values
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h04;
  localparam logic [7:0] REG_LATCH = 8'h08;
  localparam logic [1:0] CTRL_RST = 2'h0;
  localparam int CTRL_EB_EN = 0;
  localparam int CTRL_SOFT_RST = 1;
  localparam logic [3:0] DRV_LAT_RST = 4'h0;
  localparam logic [3:0] RX_LAT_RST = 4'h0;
  localparam logic [3:0] BIST_LAT_RST = 4'hF;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Asynchronous pins, all passed through the pin synchroniser
  typedef struct packed {
    logic device_reset_n;
    logic [1:0] tx_clock_select;
    logic [1:0] rx_clock_select;
    logic [1:0] serial_rate_select;
    logic tx_half_rate_select;
    logic input_select_a;
    logic input_select_b;
    logic loopback_enable;
    logic output_enable_latch_en;
    logic rx_power_latch_en;
    logic selftest_latch_en;
    logic [3:0] shared_enable_bus;
    logic tms;
    logic tclk;
    logic tdi;
    logic [1:0] freq_bad;
    logic [1:0] amp_low;
    logic [1:0] dens_low;
    logic [1:0] ser_in_primary;
    logic [1:0] ser_in_secondary;
  } tcl_pins_t;

  localparam int PIN_W = $bits(tcl_pins_t);

  // Enables presented to the analog side
  typedef struct packed {
    logic [3:0] drv_en;
    logic [1:0] rx_pwr;
    logic [3:0] selftest_n;
  } tcl_enables_t;

endpackage : tcl_pkg

// file: hdl/tcl_ctrl.sv
// Transceiver control: pin sync, enable latches, buffer, fault, JTAG, AXI
//
// Design decisions made here: register access over AXI4-Lite and the register addresses.
`timescale 1ns/1ps
module tcl_ctrl
  import tcl_pkg::*;
(
  input wire logic clk,
  input wire logic resetn,
  input wire logic ce,
  input wire tcl_pins_t pins,
  input wire logic [1:0] tx_serial,
  input wire logic eb_wr_valid,
  input wire logic [8:0] eb_wr_char,
  output logic eb_rd_valid,
  output logic [8:0] eb_rd_char,
  output tcl_enables_t enables,
  output logic [3:0] ser_out,
  output logic [1:0] cdr_in,
  output logic tx_if_ref_clk,
  output logic rx_if_ref_clk,
  output logic rx_delayed_ref_clock_out,
  output logic rx_delayed_ref_clock_oe,
  output logic [1:0] pll_rate_range,
  output logic link_fault_n_a,
  output logic link_fault_n_b,
  output logic outputs_ready,
  output logic jtag_reset,
  output logic tdo_out,
  output logic tdo_oe,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);

  typedef enum logic {JT_RESET, JT_ACTIVE} tcl_jtag_t;

  // Pin synchroniser: three stages, value moves once stages two and three agree
  logic [PIN_W-1:0] raw;
  logic [PIN_W-1:0] s1_r;
  logic [PIN_W-1:0] s2_r;
  logic [PIN_W-1:0] s3_r;
  logic [PIN_W-1:0] st_r;
  logic [PIN_W-1:0] st_nxt;
  tcl_pins_t p;

  assign raw = pins;
  assign p = st_r;

  genvar gi;
  generate
    for (gi = 0; gi < PIN_W; gi++) begin : g_sync
      always_comb begin
        st_nxt[gi] = (s2_r[gi] == s3_r[gi]) ? s3_r[gi] : st_r[gi];
      end
    end
  endgenerate

  always_ff @(posedge clk) begin
    if (!resetn) begin
      s1_r <= '0;
      s2_r <= '0;
      s3_r <= '0;
      st_r <= '0;
    end else if (ce) begin
      s1_r <= raw;
      s2_r <= s1_r;
      s3_r <= s2_r;
      st_r <= st_nxt;
    end
  end

  // Control register bits reached over the bus
  logic [1:0] ctrl_r;
  logic [1:0] ctrl_nxt;
  logic eb_enable;
  logic dev_rst;

  assign eb_enable = ctrl_r[CTRL_EB_EN];
  // Pin sampled on the reference clock, or the software reset bit
  assign dev_rst = !p.device_reset_n || ctrl_r[CTRL_SOFT_RST];

  // Enable latches: transparent while open, hold when closed
  logic [3:0] drv_lat_r;
  logic [3:0] drv_lat_nxt;
  logic [3:0] rx_lat_r;
  logic [3:0] rx_lat_nxt;
  logic [3:0] bist_lat_r;
  logic [3:0] bist_lat_nxt;
  logic [3:0] drv_eff;
  logic [3:0] rx_eff;
  logic [3:0] bist_eff;
  tcl_enables_t en_nxt;
  tcl_enables_t en_r;

  always_comb begin
    drv_lat_nxt = drv_lat_r;
    rx_lat_nxt = rx_lat_r;
    bist_lat_nxt = bist_lat_r;
    if (p.output_enable_latch_en) begin
      drv_lat_nxt = p.shared_enable_bus;
    end
    if (p.rx_power_latch_en) begin
      rx_lat_nxt = p.shared_enable_bus;
    end
    if (p.selftest_latch_en) begin
      bist_lat_nxt = p.shared_enable_bus;
    end
    if (dev_rst) begin
      drv_lat_nxt = DRV_LAT_RST;
      rx_lat_nxt = RX_LAT_RST;
    end
    // Reset only touches the self-test latch while it is closed
    if (dev_rst && !p.selftest_latch_en) begin
      bist_lat_nxt = BIST_LAT_RST;
    end
    // Open latches pass the bus, closed ones show the held value
    drv_eff = dev_rst ? DRV_LAT_RST : drv_lat_nxt;
    rx_eff = dev_rst ? RX_LAT_RST : rx_lat_nxt;
    bist_eff = bist_lat_nxt;
    // Fixed mapping: drivers A1 A2 B1 B2, receivers A B, self-test txA rxA txB rxB
    en_nxt.drv_en = drv_eff;
    en_nxt.rx_pwr = rx_eff[1:0];
    en_nxt.selftest_n = bist_eff;
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      drv_lat_r <= DRV_LAT_RST;
      rx_lat_r <= RX_LAT_RST;
      bist_lat_r <= BIST_LAT_RST;
      en_r <= {DRV_LAT_RST, RX_LAT_RST[1:0], BIST_LAT_RST};
    end else if (ce) begin
      drv_lat_r <= drv_lat_nxt;
      rx_lat_r <= rx_lat_nxt;
      bist_lat_r <= bist_lat_nxt;
      en_r <= en_nxt;
    end
  end

  assign enables = en_r;

  // Serial routing, clock selects, rate range, link fault, settle counter
  logic [3:0] ser_nxt;
  logic [3:0] ser_r;
  logic [1:0] cdr_nxt;
  logic [1:0] cdr_r;
  logic [1:0] sel;
  logic tx_ref_r;
  logic rx_ref_r;
  logic [1:0] rate_r;
  logic [1:0] rate_nxt;
  logic rate_invalid_r;
  logic [1:0] lf_n_r;
  logic [1:0] lf_n_nxt;
  logic [3:0] settle_r;
  logic [3:0] settle_nxt;

  assign sel = {p.input_select_b, p.input_select_a};

  always_comb begin
    for (int ch = 0; ch < 2; ch++) begin
      // Loopback ignores both serial inputs
      if (p.loopback_enable) begin
        cdr_nxt[ch] = tx_serial[ch];
      end else begin
        cdr_nxt[ch] = sel[ch] ? p.ser_in_primary[ch]
                              : p.ser_in_secondary[ch];
      end
      // A powered-down driver idles low; loopback drives a steady one
      for (int k = 0; k < 2; k++) begin
        ser_nxt[ch*2+k] = en_nxt.drv_en[ch*2+k] &&
                          (p.loopback_enable || tx_serial[ch]);
      end
      lf_n_nxt[ch] = !(p.freq_bad[ch] || p.amp_low[ch] ||
                       p.dens_low[ch] || !en_nxt.rx_pwr[ch]);
    end
    // Unused fourth level code keeps the last range
    case (p.serial_rate_select)
      LVL_LOW: rate_nxt = RANGE_195_400;
      LVL_MID: rate_nxt = RANGE_400_800;
      LVL_HIGH: rate_nxt = RANGE_800_1500;
      default: rate_nxt = rate_r;
    endcase
    if (dev_rst) begin
      settle_nxt = 4'h0;
    end else if (settle_r != SETTLE_CYCLES) begin
      settle_nxt = settle_r + 4'h1;
    end else begin
      settle_nxt = settle_r;
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      ser_r <= 4'h0;
      cdr_r <= 2'h0;
      tx_ref_r <= 1'b0;
      rx_ref_r <= 1'b0;
      rate_r <= RANGE_195_400;
      rate_invalid_r <= 1'b0;
      lf_n_r <= 2'h0;
      settle_r <= 4'h0;
    end else if (ce) begin
      ser_r <= ser_nxt;
      cdr_r <= cdr_nxt;
      tx_ref_r <= (p.tx_clock_select == LVL_LOW);
      rx_ref_r <= (p.rx_clock_select == LVL_LOW);
      rate_r <= rate_nxt;
      // Host misuse is only flagged, the range still follows the select
      rate_invalid_r <= p.tx_half_rate_select &&
                        (p.serial_rate_select == LVL_LOW);
      lf_n_r <= lf_n_nxt;
      settle_r <= settle_nxt;
    end
  end

  assign ser_out = ser_r;
  assign cdr_in = cdr_r;
  assign tx_if_ref_clk = tx_ref_r;
  assign rx_if_ref_clk = rx_ref_r;
  assign rx_delayed_ref_clock_oe = rx_ref_r;
  assign rx_delayed_ref_clock_out = clk;
  assign pll_rate_range = rate_r;
  assign link_fault_n_a = lf_n_r[0];
  assign link_fault_n_b = lf_n_r[1];
  assign outputs_ready = (settle_r == SETTLE_CYCLES);

  // Elasticity buffer: one character out per reference cycle
  logic [8:0] eb_mem [EB_DEPTH];
  logic [2:0] wr_ptr_r;
  logic [2:0] wr_ptr_nxt;
  logic [2:0] rd_ptr_r;
  logic [2:0] rd_ptr_nxt;
  logic [3:0] fill_r;
  logic [3:0] fill_nxt;
  logic [8:0] rd_char_nxt;
  logic [8:0] rd_char_r;
  logic rd_valid_r;
  logic push;
  logic pop;
  logic eb_drop;
  logic eb_ins;

  always_comb begin
    // Drop only a framing character, and only at or above the high watermark
    eb_drop = eb_enable && eb_wr_valid && (eb_wr_char == K28_5) &&
              (fill_r >= EB_HIGH_MARK);
    push = eb_enable && eb_wr_valid && !eb_drop && (fill_r != EB_FULL);
    // Insert only right after a framing character has gone out, and only at or below the low watermark
    eb_ins = (fill_r <= EB_LOW_MARK) && (rd_char_r == K28_5);
    pop = eb_enable && !eb_ins && (fill_r != 4'h0);
    wr_ptr_nxt = push ? wr_ptr_r + 3'h1 : wr_ptr_r;
    rd_ptr_nxt = pop ? rd_ptr_r + 3'h1 : rd_ptr_r;
    fill_nxt = fill_r + {3'h0, push} - {3'h0, pop};
    if (!eb_enable) begin
      rd_char_nxt = eb_wr_char;
    end else if (pop) begin
      rd_char_nxt = eb_mem[rd_ptr_r];
    end else begin
      rd_char_nxt = K28_5;
    end
    if (dev_rst) begin
      wr_ptr_nxt = EB_NOMINAL;
      rd_ptr_nxt = 3'h0;
      fill_nxt = {1'b0, EB_NOMINAL};
      rd_char_nxt = K28_5;
    end
  end

  // Buffer entries restart as framing characters so reads stay defined
  generate
    for (gi = 0; gi < EB_DEPTH; gi++) begin : g_eb
      always_ff @(posedge clk) begin
        if (!resetn) begin
          eb_mem[gi] <= K28_5;
        end else if (ce && (dev_rst || (push && wr_ptr_r == gi))) begin
          eb_mem[gi] <= dev_rst ? K28_5 : eb_wr_char;
        end
      end
    end
  endgenerate

  always_ff @(posedge clk) begin
    if (!resetn) begin
      wr_ptr_r <= EB_NOMINAL;
      rd_ptr_r <= 3'h0;
      fill_r <= {1'b0, EB_NOMINAL};
      rd_char_r <= K28_5;
      rd_valid_r <= 1'b0;
    end else if (ce) begin
      wr_ptr_r <= wr_ptr_nxt;
      rd_ptr_r <= rd_ptr_nxt;
      fill_r <= fill_nxt;
      rd_char_r <= rd_char_nxt;
      rd_valid_r <= !dev_rst && (eb_enable || eb_wr_valid);
    end
  end

  assign eb_rd_char = rd_char_r;
  assign eb_rd_valid = rd_valid_r;

  // Test access port: TMS high on six TCLK edges in a row resets it
  tcl_jtag_t jt_r;
  tcl_jtag_t jt_nxt;
  logic tclk_prev_r;
  logic tclk_rise;
  logic [2:0] tms_cnt_r;
  logic [2:0] tms_cnt_nxt;
  logic tdo_r;
  logic tdo_nxt;
  logic jrst_nxt;
  logic jrst_r;

  assign tclk_rise = p.tclk && !tclk_prev_r;

  always_comb begin
    jt_nxt = jt_r;
    tms_cnt_nxt = tms_cnt_r;
    tdo_nxt = tdo_r;
    jrst_nxt = 1'b0;
    if (tclk_rise) begin
      tdo_nxt = p.tdi;
      if (!p.tms) begin
        tms_cnt_nxt = 3'h0;
      end else if (tms_cnt_r <= TMS_RESET_EDGES) begin
        tms_cnt_nxt = tms_cnt_r + 3'h1;
      end
      case (jt_r)
        JT_RESET: if (!p.tms) jt_nxt = JT_ACTIVE;
        JT_ACTIVE: begin
          if (p.tms && tms_cnt_r == TMS_RESET_EDGES) begin
            jt_nxt = JT_RESET;
            jrst_nxt = 1'b1;
          end
        end
        default: jt_nxt = JT_RESET;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      jt_r <= JT_RESET;
      tclk_prev_r <= 1'b0;
      tms_cnt_r <= 3'h0;
      tdo_r <= 1'b0;
      jrst_r <= 1'b0;
    end else if (ce) begin
      jt_r <= jt_nxt;
      tclk_prev_r <= p.tclk;
      tms_cnt_r <= tms_cnt_nxt;
      tdo_r <= tdo_nxt;
      jrst_r <= jrst_nxt;
    end
  end

  assign jtag_reset = jrst_r;
  assign tdo_out = tdo_r;
  assign tdo_oe = (jt_r == JT_ACTIVE);

  // AXI4-Lite slave: write needs address and data together, one at a time
  logic bvalid_r;
  logic bvalid_nxt;
  logic [1:0] bresp_r;
  logic [1:0] bresp_nxt;
  logic rvalid_r;
  logic rvalid_nxt;
  logic [31:0] rdata_r;
  logic [31:0] rdata_nxt;
  logic [1:0] rresp_r;
  logic [1:0] rresp_nxt;
  logic wr_take;
  logic rd_take;

  assign wr_take = s_axi_awvalid && s_axi_wvalid && !bvalid_r;
  assign rd_take = s_axi_arvalid && !rvalid_r;
  assign s_axi_awready = wr_take;
  assign s_axi_wready = wr_take;
  assign s_axi_arready = !rvalid_r;

  always_comb begin
    ctrl_nxt = ctrl_r;
    bvalid_nxt = bvalid_r && !s_axi_bready;
    bresp_nxt = bresp_r;
    rvalid_nxt = rvalid_r && !s_axi_rready;
    rdata_nxt = rdata_r;
    rresp_nxt = rresp_r;
    if (wr_take) begin
      bvalid_nxt = 1'b1;
      bresp_nxt = RESP_OKAY;
      case (s_axi_awaddr)
        REG_CTRL: if (s_axi_wstrb[0]) ctrl_nxt = s_axi_wdata[1:0];
        REG_STATUS, REG_LATCH: bresp_nxt = RESP_OKAY;
        default: bresp_nxt = RESP_SLVERR;
      endcase
    end
    if (rd_take) begin
      rvalid_nxt = 1'b1;
      rresp_nxt = RESP_OKAY;
      case (s_axi_araddr)
        REG_CTRL: rdata_nxt = {30'h0, ctrl_r};
        REG_STATUS: rdata_nxt = {19'h0, fill_r, jt_r == JT_ACTIVE,
                                 ~lf_n_r, rate_invalid_r, rate_r,
                                 rx_ref_r, tx_ref_r, outputs_ready};
        REG_LATCH: rdata_nxt = {20'h0, bist_lat_r, rx_lat_r, drv_lat_r};
        default: begin
          rdata_nxt = 32'h0;
          rresp_nxt = RESP_SLVERR;
        end
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      ctrl_r <= CTRL_RST;
      bvalid_r <= 1'b0;
      bresp_r <= RESP_OKAY;
      rvalid_r <= 1'b0;
      rdata_r <= 32'h0;
      rresp_r <= RESP_OKAY;
    end else if (ce) begin
      ctrl_r <= ctrl_nxt;
      bvalid_r <= bvalid_nxt;
      bresp_r <= bresp_nxt;
      rvalid_r <= rvalid_nxt;
      rdata_r <= rdata_nxt;
      rresp_r <= rresp_nxt;
    end
  end

  assign s_axi_bvalid = bvalid_r;
  assign s_axi_bresp = bresp_r;
  assign s_axi_rvalid = rvalid_r;
  assign s_axi_rdata = rdata_r;
  assign s_axi_rresp = rresp_r;

  // Checks on the control behaviour
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  a_tx_ref_select: assert property (
    ce && p.tx_clock_select == LVL_LOW |=> tx_if_ref_clk)
    else $error("tx interface not on reference clock");
  a_rx_delayed_oe: assert property (
    ce && p.rx_clock_select != LVL_LOW |=> !rx_delayed_ref_clock_oe)
    else $error("delayed clock enabled in wrong mode");
  a_rate_mid_range: assert property (
    ce && p.serial_rate_select == LVL_MID |=> pll_rate_range == RANGE_400_800)
    else $error("rate range wrong for MID");
  a_eb_reset_ptrs: assert property (
    ce && dev_rst |=> wr_ptr_r == EB_NOMINAL && rd_ptr_r == 3'h0)
    else $error("buffer pointers not at nominal offset");
  a_ready_after_rst: assert property (
    (ce && !dev_rst) [*8] |=> outputs_ready)
    else $error("outputs not ready after settle time");
  a_eb_insert_k: assert property (
    ce && eb_enable && eb_ins && !dev_rst |=>
      eb_rd_char == K28_5 && rd_ptr_r == $past(rd_ptr_r))
    else $error("framing insert missing");
  a_eb_drop_frame: assert property (
    ce && eb_drop && !dev_rst |=> wr_ptr_r == $past(wr_ptr_r))
    else $error("framing character not dropped");
  a_cdr_primary: assert property (
    ce && !p.loopback_enable && p.input_select_a |=>
      cdr_in[0] == $past(p.ser_in_primary[0]))
    else $error("primary input not routed");
  a_loop_drive_one: assert property (
    ce && p.loopback_enable |=> ser_out == enables.drv_en)
    else $error("loopback drivers not at one");
  a_drv_pass_bus: assert property (
    ce && p.output_enable_latch_en && !dev_rst |=>
      enables.drv_en == $past(p.shared_enable_bus))
    else $error("driver enables not transparent");
  a_drv_reset_clear: assert property (
    ce && dev_rst |=> drv_lat_r == DRV_LAT_RST && enables.drv_en == 4'h0)
    else $error("driver latch not cleared");
  a_rx_reset_clear: assert property (
    ce && dev_rst |=> enables.rx_pwr == 2'h0)
    else $error("receive power not cleared");
  a_bist_reset_closed: assert property (
    ce && dev_rst && !p.selftest_latch_en |=> bist_lat_r == BIST_LAT_RST)
    else $error("self-test latch not cleared");
  a_fault_rx_off: assert property (
    ce && !en_nxt.rx_pwr[0] |=> !link_fault_n_a)
    else $error("link fault missing for disabled receiver");
  a_tms_reset: assert property (
    ce && tclk_rise && p.tms && tms_cnt_r == TMS_RESET_EDGES |=>
      jtag_reset ##1 !tdo_oe)
    else $error("test controller not reset");
  a_tdo_hiz: assert property (
    jt_r == JT_RESET && !(ce && tclk_rise && !p.tms) |=> !tdo_oe)
    else $error("TDO driven outside test mode");

endmodule : tcl_ctrl

// file: verif/tcl_host.sv
// Host controller model that drives the transceiver control pins
`timescale 1ns/1ps
module tcl_host
  import tcl_pkg::*;
(
  input wire logic clk,
  input wire logic resetn,
  input wire tcl_pins_t pin_req,
  output tcl_pins_t pins
);
  logic [3:0] boot_cnt_r;

  // Power-up timer for the initial device reset pulse
  always_ff @(posedge clk) begin
    if (!resetn) begin
      boot_cnt_r <= 4'h0;
    end else if (!boot_cnt_r[3]) begin
      boot_cnt_r <= boot_cnt_r + 4'h1;
    end
  end

  // Pins change only after an edge, as a real host's flops would
  always_ff @(posedge clk) begin
    pins <= pin_req;
    // Buffer pointers need a known start, so reset after power-up
    pins.device_reset_n <= pin_req.device_reset_n && boot_cnt_r[3];
    // Half-rate reference is never offered with the lowest range
    if (pin_req.serial_rate_select == LVL_LOW) begin
      pins.tx_half_rate_select <= 1'b0;
    end
  end
endmodule : tcl_host

// file: verif/tcl_ctrl_tb.sv
// Self-checking bench for the transceiver control block
`timescale 1ns/1ps
module tcl_ctrl_tb;
  import tcl_pkg::*;
  logic clk, resetn, eb_wr_valid, eb_rd_valid, tx_if_ref_clk, rx_if_ref_clk;
  logic rx_delayed_ref_clock_out, rx_delayed_ref_clock_oe, outputs_ready;
  logic link_fault_n_a, link_fault_n_b, jtag_reset, tdo_oe, jr_seen;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic s_axi_rvalid, s_axi_rready;
  logic [1:0] tx_serial, cdr_in, pll_rate_range, s_axi_bresp, s_axi_rresp, rr;
  logic [3:0] ser_out, s_axi_wstrb;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic [8:0] eb_wr_char, eb_rd_char;
  logic [31:0] s_axi_wdata, s_axi_rdata, rd;
  tcl_pins_t pin_req, pins;
  tcl_enables_t enables;
  int bad_count, n_checks, n;

  tcl_ctrl dut_u (.clk, .resetn, .ce(1'b1), .pins, .tx_serial, .eb_wr_valid,
    .eb_wr_char, .eb_rd_valid, .eb_rd_char, .enables, .ser_out, .cdr_in,
    .tx_if_ref_clk, .rx_if_ref_clk, .rx_delayed_ref_clock_out,
    .rx_delayed_ref_clock_oe, .pll_rate_range, .link_fault_n_a,
    .link_fault_n_b, .outputs_ready, .jtag_reset, .tdo_out(), .tdo_oe,
    .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready);
  tcl_host host_u (.clk, .resetn, .pin_req, .pins);

  // 20 MHz reference
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  // The controller reset is a one-cycle pulse, so remember it
  always @(posedge clk) if (jtag_reset === 1'b1) jr_seen <= 1'b1;

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  // Pins pass the host flop and the sync chain, so allow nine edges
  task automatic settle;
    repeat (9) @(posedge clk);
    @(negedge clk);
  endtask : settle

  task automatic tend(input string s);
    $display("test %s done, %0d checks so far", s, n_checks);
  endtask : tend

  // Ready is looked at mid-cycle, where it equals what the next edge sees
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
    @(negedge clk);
    while (s_axi_awready !== 1'b1 || s_axi_wready !== 1'b1) @(negedge clk);
    @(posedge clk);
    {s_axi_awvalid, s_axi_wvalid} <= 2'h0;
    @(negedge clk);
    while (s_axi_bvalid !== 1'b1) @(negedge clk);
    rr = s_axi_bresp;
    @(posedge clk);
    s_axi_bready <= 1'b0;
  endtask : axi_wr

  task automatic axi_rd(input logic [7:0] a);
    @(posedge clk);
    s_axi_araddr <= a;
    {s_axi_arvalid, s_axi_rready} <= 2'h3;
    @(negedge clk);
    while (s_axi_arready !== 1'b1) @(negedge clk);
    @(posedge clk);
    s_axi_arvalid <= 1'b0;
    @(negedge clk);
    while (s_axi_rvalid !== 1'b1) @(negedge clk);
    rd = s_axi_rdata;
    rr = s_axi_rresp;
    @(posedge clk);
    s_axi_rready <= 1'b0;
  endtask : axi_rd

  // One full test-clock period on the slow pin
  task automatic tck;
    @(posedge clk);
    pin_req.tclk <= 1'b1;
    settle;
    @(posedge clk);
    pin_req.tclk <= 1'b0;
    settle;
  endtask : tck

  task automatic finish_test;
    $display("checks made %0d, mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : finish_test

  // Cut a hang short; the whole run needs well under 2000 cycles
  initial begin
    repeat (6000) @(posedge clk);
    bad_count++;
    finish_test;
  end

  initial begin
    {bad_count, n_checks, jr_seen, resetn, tx_serial} = '0;
    pin_req = '0;
    {pin_req.device_reset_n, pin_req.input_select_a} = 2'h3;
    pin_req.tx_clock_select = LVL_MID;
    pin_req.rx_clock_select = LVL_MID;
    {eb_wr_valid, eb_wr_char, s_axi_awaddr, s_axi_awvalid, s_axi_wdata} = '0;
    {s_axi_wvalid, s_axi_bready, s_axi_araddr, s_axi_arvalid} = '0;
    s_axi_rready = 1'b0;
    s_axi_wstrb = 4'hF;
    repeat (12) @(posedge clk);
    resetn <= 1'b1;
    repeat (3) settle;
    chk(32'(enables), {22'h0, 4'h0, 2'h0, 4'hF});
    chk(32'(link_fault_n_a), 32'h0);
    chk(32'(tdo_oe), 32'h0);
    axi_rd(8'h40);
    chk({rd[29:0], rr}, {30'h0, RESP_SLVERR});
    tend("reset_values");
    // Every level of the three-level selects
    for (int i = 0; i < 3; i++) begin
      @(posedge clk);
      pin_req.tx_clock_select <= 2'(i);
      pin_req.rx_clock_select <= 2'(i);
      pin_req.serial_rate_select <= 2'(i);
      pin_req.tx_half_rate_select <= 1'b1;
      settle;
      chk(32'({tx_if_ref_clk, rx_if_ref_clk}), (i == 0) ? 32'h3 : 32'h0);
      chk(32'(rx_delayed_ref_clock_oe), (i == 0) ? 32'h1 : 32'h0);
      chk(32'(pll_rate_range), 32'(i));
      axi_rd(REG_STATUS);
      chk(32'(rd[5:3]), 32'(i));
    end
    tend("selects");
    @(posedge clk);
    {pin_req.output_enable_latch_en, pin_req.rx_power_latch_en} <= 2'h3;
    pin_req.selftest_latch_en <= 1'b1;
    pin_req.shared_enable_bus <= 4'h5;
    settle;
    chk(32'(enables), {22'h0, 4'h5, 2'h1, 4'h5});
    chk(32'({link_fault_n_b, link_fault_n_a}), 32'h1);
    @(posedge clk);
    pin_req.freq_bad <= 2'h1;
    settle;
    chk(32'(link_fault_n_a), 32'h0);
    @(posedge clk);
    pin_req.freq_bad <= 2'h0;
    pin_req.shared_enable_bus <= 4'hA;
    settle;
    // Close all latches, then move the bus: latched values must hold
    @(posedge clk);
    {pin_req.output_enable_latch_en, pin_req.rx_power_latch_en} <= 2'h0;
    pin_req.selftest_latch_en <= 1'b0;
    settle;
    @(posedge clk);
    pin_req.shared_enable_bus <= 4'h0;
    settle;
    chk(32'(enables), {22'h0, 4'hA, 2'h2, 4'hA});
    @(posedge clk);
    pin_req.device_reset_n <= 1'b0;
    settle;
    chk(32'(enables), {22'h0, 4'h0, 2'h0, 4'hF});
    chk(32'(outputs_ready), 32'h0);
    @(posedge clk);
    pin_req.device_reset_n <= 1'b1;
    n = 0;
    while (outputs_ready !== 1'b1 && n < 40) begin
      @(negedge clk);
      n++;
    end
    chk(32'(n < 21), 32'h1);
    tend("latches_and_reset");
    @(posedge clk);
    {pin_req.output_enable_latch_en, pin_req.loopback_enable} <= 2'h3;
    pin_req.shared_enable_bus <= 4'hF;
    {pin_req.ser_in_primary, pin_req.ser_in_secondary} <= 4'h6;
    tx_serial <= 2'h2;
    settle;
    chk(32'(ser_out), 32'hF);
    chk(32'(cdr_in), 32'h2);
    for (int j = 1; j < 3; j++) begin
      @(posedge clk);
      pin_req.loopback_enable <= 1'b0;
      {pin_req.input_select_b, pin_req.input_select_a} <= 2'(j);
      settle;
      chk(32'(cdr_in), (j == 1) ? 32'h3 : 32'h0);
    end
    tend("serial_routing");
    // Buffer on: the four reset entries drain, then the stream shows through
    @(posedge clk);
    {eb_wr_valid, eb_wr_char} <= {1'b1, 9'h055};
    axi_wr(REG_CTRL, 32'h1);
    chk(32'(rr), 32'(RESP_OKAY));
    settle;
    chk(32'({eb_rd_valid, eb_rd_char}), 32'h255);
    // Writes stop: buffer runs dry and fills the gap with framing characters
    @(posedge clk);
    eb_wr_valid <= 1'b0;
    settle;
    chk(32'(eb_rd_char), 32'(K28_5));
    axi_rd(REG_STATUS);
    chk(32'(rd[12:9]), 32'h0);
    // Software device reset clears the driver and receive latches
    axi_wr(REG_CTRL, 32'h2);
    settle;
    chk(32'(enables), {22'h0, 4'h0, 2'h0, 4'hF});
    axi_rd(REG_CTRL);
    chk(rd, 32'h2);
    axi_wr(REG_CTRL, 32'h0);
    settle;
    tend("buffer_and_ctrl");
    @(posedge clk);
    pin_req.tms <= 1'b0;
    tck;
    @(posedge clk);
    pin_req.tms <= 1'b1;
    jr_seen <= 1'b0;
    repeat (5) tck;
    chk(32'(jr_seen), 32'h0);
    tck;
    chk(32'(jr_seen), 32'h1);
    chk(32'(tdo_oe), 32'h0);
    tend("test_port");
    finish_test;
  end
endmodule : tcl_ctrl_tb
